//--- verilog/pinit_sequencer.sv
// Power-up initialization sequencer: silent, configuration, status phases.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - After reset the block walks a silent phase, a configuration phase and a status phase in that order.
// - Once the status phase ends the block enters normal mode and stays there until reset.
// - In asynchronous mode every initialization word goes out under source identifier 0 only.
// - In synchronous mode the same word goes out once in the slot of each enabled source identifier.
// - In daisy chain mode every word goes out in the source identifier 0 slot.
// - The silent phase waits the settle delay, then the filter start time, then opens the watch window.
// - If no programming entry is seen within the watch window the configuration phase begins.
// - Each nibble is sent as an ID word then a data word, the pair repeated k times, nibbles ascending.
// - Each nibble repetition costs exactly two periods, the ID word in one and the data word in the next.
// - The configuration phase covers 32 nibbles, or 48 when extended initialization is selected.
// - The repetition count k is 8 in asynchronous mode and 4 in synchronous mode.
// - ID words use codes 0x200 to 0x20f for block IDs 1 to 16.
// - Data words use codes 0x210 to 0x21f for nibble values 0 to 15.
// - Nibbles 2 and 3 carry the block count, 0010 0000 normally or 0011 0000 when extended.
// - Nibble 1 carries user byte 0 low, nibbles 4 to 9 carry user bytes 1 to 3 low then high.

module pinit_sequencer
    import pinit_pkg::*;
#(
    parameter logic [15:0] POR_SETTLE_US = 16'd1000,
    parameter logic [15:0] FILTER_START_US = 16'd500,
    parameter logic [15:0] PME_WINDOW_US = 16'd2000,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic SYNC_PULSE,
    input wire logic PROG_ENTRY,
    input wire logic SELFTEST_DONE,
    input wire logic SELFTEST_FAIL,
    input wire logic TX_READY,
    output logic TX_VALID,
    output pinit_word_type TX_WORD,
    output logic [1:0] INIT_PHASE,
    output logic NORMAL_MODE
);

    // ----------------------------------------------------------------
    // State and storage
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_SETTLE,
        ST_FILTER,
        ST_WATCH,
        ST_PROGRAM,
        ST_CFG_WAIT,
        ST_CFG_EMIT,
        ST_STAT_WAIT,
        ST_STAT_EMIT,
        ST_NORMAL
    } pinit_state_type;

    pinit_state_type state_reg;
    pinit_state_type state_next;
    logic [7:0] link_configuration_reg;
    logic [31:0] user_data_reg;
    logic [31:0] rdata_reg;
    logic [15:0] timer_reg;
    logic [1:0] slot_reg;
    logic is_data_reg;
    logic [3:0] rep_reg;
    logic [5:0] nib_reg;
    logic [9:0] stat_code_reg;
    logic final_reg;
    logic fail_reg;
    logic [1:0] phase_reg;
    logic normal_reg;
    logic sp_meta_reg;
    logic sp_sync_reg;
    logic sp_prev_reg;
    logic pe_meta_reg;
    logic pe_sync_reg;
    logic us_tick;
    logic fifo_in_ready;
    logic [3:0] nib_val;

    // ----------------------------------------------------------------
    // Register decode and configuration fields
    // ----------------------------------------------------------------
    wire logic sel_cfg = (ADDR == REG_CFG_OFF);
    wire logic sel_user = (ADDR == REG_USER_OFF);
    wire logic sel_stat = (ADDR == REG_STAT_OFF);
    wire logic [1:0] mode = link_configuration_reg[CFG_MODE_LSB +: 2];
    wire logic extended_init_fields_sel =
        link_configuration_reg[CFG_EXT_INIT_BIT];
    wire logic extended_error_msg_sel =
        link_configuration_reg[CFG_EXT_ERR_BIT];
    wire logic [3:0] slot_mask = link_configuration_reg[CFG_MASK_LSB +: 4];
    wire logic [7:0] user_byte_0 = user_data_reg[7:0];
    wire logic [7:0] user_byte_1 = user_data_reg[15:8];
    wire logic [7:0] user_byte_2 = user_data_reg[23:16];
    wire logic [7:0] user_byte_3 = user_data_reg[31:24];
    wire logic is_async = (mode == MODE_ASYNC);
    wire logic is_sync = (mode == MODE_SYNC);

    wire logic [31:0] stat_word = {10'h000, nib_reg, 4'h0, rep_reg,
        3'h0, is_data_reg, (state_reg == ST_PROGRAM), normal_reg,
        phase_reg};
    wire logic [31:0] rd_mux =
        sel_cfg ? {24'h000000, link_configuration_reg} :
        sel_user ? user_data_reg :
        sel_stat ? stat_word : 32'h0000_0000;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    // Time bases count microseconds so the 16-bit timer covers every
    // window without a wide cycle counter.
    pinit_tick #(
        .DIV(CYCLES_PER_US)
    ) u_tick (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .tick(us_tick)
    );

    wire logic [15:0] limit_sel =
        (state_reg == ST_SETTLE) ? POR_SETTLE_US :
        (state_reg == ST_FILTER) ? FILTER_START_US :
        (state_reg == ST_WATCH) ? PME_WINDOW_US : ASYNC_PERIOD_US;
    wire logic timeout = us_tick && (timer_reg == limit_sel - 16'd1);
    wire logic sync_edge = sp_sync_reg && !sp_prev_reg;
    wire logic wait_st = (state_reg == ST_CFG_WAIT) ||
        (state_reg == ST_STAT_WAIT);
    // Asynchronous mode paces itself; the other modes follow the sync line.
    wire logic period_evt = wait_st &&
        (is_async ? timeout : sync_edge);

    // ----------------------------------------------------------------
    // Word selection
    // ----------------------------------------------------------------
    wire logic [3:0] k_sel = is_async ? K_ASYNC : K_SYNC;
    wire logic [5:0] fields_sel =
        extended_init_fields_sel ? FIELDS_EXT : FIELDS_STD;
    wire logic [3:0] id_idx = 4'(nib_reg - 6'd1);

    always_comb begin
        case (nib_reg)
            6'd1: nib_val = user_byte_0[3:0];
            6'd2: nib_val = extended_init_fields_sel ?
                COUNT_EXT_HI : COUNT_STD_HI;
            6'd3: nib_val = COUNT_LO;
            6'd4: nib_val = user_byte_1[3:0];
            6'd5: nib_val = user_byte_1[7:4];
            6'd6: nib_val = user_byte_2[3:0];
            6'd7: nib_val = user_byte_2[7:4];
            6'd8: nib_val = user_byte_3[3:0];
            6'd9: nib_val = user_byte_3[7:4];
            default: nib_val = 4'h0;
        endcase
    end

    wire logic [9:0] cfg_code = is_data_reg ?
        {CODE_DATA_BASE[9:4], nib_val} :
        {CODE_ID_BASE[9:4], id_idx};
    wire logic [9:0] defect_code =
        extended_error_msg_sel ? CODE_ST_ERR : CODE_DEFECT;
    wire logic [9:0] status_now = !SELFTEST_DONE ? CODE_BUSY :
        SELFTEST_FAIL ? defect_code : CODE_READY;

    // ----------------------------------------------------------------
    // Slot emission into the FIFO
    // ----------------------------------------------------------------
    wire logic emit_st = (state_reg == ST_CFG_EMIT) ||
        (state_reg == ST_STAT_EMIT);
    wire logic slot_en = is_sync ? slot_mask[slot_reg] :
        (slot_reg == 2'd0);
    wire logic push = emit_st && slot_en;
    wire logic accept = emit_st && (!slot_en || fifo_in_ready);
    wire logic emit_done = accept && (slot_reg == 2'd3);
    wire logic last_cfg = is_data_reg && (rep_reg == k_sel - 4'd1) &&
        (nib_reg == fields_sel);
    pinit_word_type push_word;
    assign push_word = {slot_reg, (state_reg == ST_STAT_EMIT) ?
        stat_code_reg : cfg_code};

    pinit_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(push_word),
        .out_valid(TX_VALID),
        .out_ready(TX_READY),
        .out_data(TX_WORD)
    );

    // ----------------------------------------------------------------
    // Phase sequencing
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_SETTLE: if (timeout) state_next = ST_FILTER;
            ST_FILTER: if (timeout) state_next = ST_WATCH;
            ST_WATCH: begin
                if (pe_sync_reg) begin
                    state_next = ST_PROGRAM;
                end else if (timeout) begin
                    state_next = ST_CFG_WAIT;
                end
            end
            ST_CFG_WAIT: if (period_evt) state_next = ST_CFG_EMIT;
            ST_CFG_EMIT: begin
                if (emit_done) begin
                    state_next = last_cfg ? ST_STAT_WAIT : ST_CFG_WAIT;
                end
            end
            ST_STAT_WAIT: if (period_evt) state_next = ST_STAT_EMIT;
            ST_STAT_EMIT: begin
                if (emit_done) begin
                    state_next = final_reg ? ST_NORMAL : ST_STAT_WAIT;
                end
            end
            ST_PROGRAM, ST_NORMAL: state_next = state_reg;
        endcase
    end

    wire logic [1:0] phase_next =
        (state_next == ST_NORMAL) ? 2'd0 :
        (state_next == ST_STAT_WAIT || state_next == ST_STAT_EMIT) ? 2'd3 :
        (state_next == ST_CFG_WAIT || state_next == ST_CFG_EMIT) ? 2'd2 :
        2'd1;

    // Reset restarts the whole walk from the silent phase.
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= ST_SETTLE;
            phase_reg <= 2'd1;
            normal_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            normal_reg <= (state_next == ST_NORMAL);
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            timer_reg <= 16'h0000;
        end else if (state_next != state_reg || period_evt) begin
            timer_reg <= 16'h0000;
        end else if (us_tick) begin
            timer_reg <= timer_reg + 16'd1;
        end
    end

    // ID/data toggle, repetition and nibble counters advance per emission.
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            slot_reg <= 2'd0;
            is_data_reg <= 1'b0;
            rep_reg <= 4'h0;
            nib_reg <= 6'd1;
        end else begin
            if (accept) begin
                slot_reg <= slot_reg + 2'd1;
            end
            if (emit_done && state_reg == ST_CFG_EMIT) begin
                is_data_reg <= !is_data_reg;
                if (is_data_reg) begin
                    if (rep_reg == k_sel - 4'd1) begin
                        rep_reg <= 4'h0;
                        nib_reg <= nib_reg + 6'd1;
                    end else begin
                        rep_reg <= rep_reg + 4'd1;
                    end
                end
            end
        end
    end

    // Latching the status once per period keeps every slot identical.
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            stat_code_reg <= CODE_BUSY;
            final_reg <= 1'b0;
            fail_reg <= 1'b0;
        end else if (period_evt && state_reg == ST_STAT_WAIT) begin
            stat_code_reg <= status_now;
            final_reg <= SELFTEST_DONE;
            fail_reg <= SELFTEST_DONE && SELFTEST_FAIL;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sp_meta_reg <= 1'b0;
            sp_sync_reg <= 1'b0;
            sp_prev_reg <= 1'b0;
            pe_meta_reg <= 1'b0;
            pe_sync_reg <= 1'b0;
        end else begin
            sp_meta_reg <= SYNC_PULSE;
            sp_sync_reg <= sp_meta_reg;
            sp_prev_reg <= sp_sync_reg;
            pe_meta_reg <= PROG_ENTRY;
            pe_sync_reg <= pe_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    // Configuration writes are accepted at any time, but a change during
    // the configuration phase mixes old and new settings in one sequence.
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            link_configuration_reg <= CFG_RESET;
            user_data_reg <= USER_RESET;
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (WR && sel_cfg) begin
                link_configuration_reg <= WDATA[7:0];
            end
            if (WR && sel_user) begin
                user_data_reg <= WDATA;
            end
            rdata_reg <= RD ? rd_mux : 32'h0000_0000;
        end
    end

    assign RDATA = rdata_reg;
    assign INIT_PHASE = phase_reg;
    assign NORMAL_MODE = normal_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    silent_phase_a: assert property (
        (phase_reg == 2'd1) |-> !push)
        else $error("Word pushed during the silent phase");
    normal_sticky_a: assert property (
        normal_reg |=> normal_reg && state_reg == ST_NORMAL)
        else $error("Normal mode was left");
    async_slot_a: assert property (
        push && mode == MODE_ASYNC |-> slot_reg == 2'd0)
        else $error("Asynchronous word outside slot 0");
    sync_slot_a: assert property (
        push |-> !is_sync || slot_mask[slot_reg])
        else $error("Synchronous word in a disabled slot");
    daisy_slot_a: assert property (
        push && mode == MODE_DAISY |-> slot_reg == 2'd0)
        else $error("Daisy chain word outside slot 0");
    settle_order_a: assert property (
        state_reg == ST_SETTLE |=> state_reg inside {ST_SETTLE, ST_FILTER})
        else $error("Settle delay skipped");
    watch_exit_a: assert property (
        state_reg == ST_WATCH && timeout && !pe_sync_reg |=>
        state_reg == ST_CFG_WAIT && phase_reg == 2'd2)
        else $error("Watch window did not lead to configuration");
    id_code_a: assert property (
        push && state_reg == ST_CFG_EMIT && !is_data_reg |->
        push_word.code == CODE_ID_BASE + {6'h00, id_idx})
        else $error("Wrong ID code");
    count_field_a: assert property (
        push && state_reg == ST_CFG_EMIT && is_data_reg && nib_reg == 6'd2
        |-> push_word.code[3:0] ==
        (extended_init_fields_sel ? 4'h3 : 4'h2))
        else $error("Wrong block count nibble");
    rep_bound_a: assert property (
        rep_reg < (is_async ? 4'd8 : 4'd4) || $changed(mode))
        else $error("Repetition count out of range");
    busy_code_a: assert property (
        period_evt && state_reg == ST_STAT_WAIT && !SELFTEST_DONE |=>
        stat_code_reg == 10'h1e8 && !final_reg)
        else $error("Busy code not latched while self-test runs");
    final_code_a: assert property (
        final_reg |-> stat_code_reg == (fail_reg ? defect_code : CODE_READY))
        else $error("Final status code does not match self-test result");

endmodule : pinit_sequencer

`default_nettype wire

//--- verilog/pinit_pkg.sv
// Shared constants and types for the power-up initialization sequencer.
`default_nettype none

package pinit_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 40_000_000;
    localparam int US_PER_SEC = 1_000_000;
    localparam int CYCLES_PER_US = CLK_FREQ_HZ / US_PER_SEC;
    localparam logic [15:0] ASYNC_PERIOD_US = 16'd228;

    // ----------------------------------------------------------------
    // Register map, byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CFG_OFF = 8'h00;
    localparam logic [7:0] REG_USER_OFF = 8'h04;
    localparam logic [7:0] REG_STAT_OFF = 8'h08;

    // Fields of link_configuration_reg.
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_EXT_INIT_BIT = 2;
    localparam int CFG_EXT_ERR_BIT = 3;
    localparam int CFG_MASK_LSB = 4;
    localparam logic [7:0] CFG_RESET = 8'h10;
    localparam logic [31:0] USER_RESET = 32'h0000_0000;

    // Fields of the status register.
    localparam int STAT_PHASE_LSB = 0;
    localparam int STAT_NORMAL_BIT = 2;
    localparam int STAT_PROG_BIT = 3;
    localparam int STAT_DATA_BIT = 4;
    localparam int STAT_REP_LSB = 8;
    localparam int STAT_NIB_LSB = 16;

    // Link mode encodings held in the configuration register.
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_SYNC = 2'h1;
    localparam logic [1:0] MODE_DAISY = 2'h2;

    // ----------------------------------------------------------------
    // Sequence constants and reserved 10-bit codes
    // ----------------------------------------------------------------
    localparam logic [5:0] FIELDS_STD = 6'h20;
    localparam logic [5:0] FIELDS_EXT = 6'h30;
    localparam logic [3:0] K_ASYNC = 4'h8;
    localparam logic [3:0] K_SYNC = 4'h4;
    localparam logic [3:0] COUNT_STD_HI = 4'h2;
    localparam logic [3:0] COUNT_EXT_HI = 4'h3;
    localparam logic [3:0] COUNT_LO = 4'h0;
    localparam logic [9:0] CODE_ID_BASE = 10'h200;
    localparam logic [9:0] CODE_DATA_BASE = 10'h210;
    localparam logic [9:0] CODE_BUSY = 10'h1e8;
    localparam logic [9:0] CODE_READY = 10'h1e7;
    localparam logic [9:0] CODE_DEFECT = 10'h1f4;
    localparam logic [9:0] CODE_ST_ERR = 10'h1ea;

    typedef struct packed {
        logic [1:0] slot;
        logic [9:0] code;
    } pinit_word_type;

    localparam int WORD_W = $bits(pinit_word_type);

endpackage : pinit_pkg

`default_nettype wire

//--- verilog/pinit_tick.sv
// Divider that makes a one-cycle enable pulse every DIV clocks.
`timescale 1ns/1ps
`default_nettype none

module pinit_tick #(
    parameter int DIV = 40
) (
    input wire logic clk,
    input wire logic rst_b,
    output logic tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_reg;
    wire logic at_last = (cnt_reg == LAST);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= at_last ? '0 : cnt_reg + 1'b1;
            tick <= at_last;
        end
    end

endmodule : pinit_tick

`default_nettype wire

//--- verilog/pinit_fifo.sv
// Word FIFO with a registered output stage and valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module pinit_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] cnt_reg;

    assign in_ready = (cnt_reg != FULL_CNT);
    wire logic push = in_valid && in_ready;
    wire logic load = (cnt_reg != '0) && (!out_valid || out_ready);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            wr_ptr_reg <= push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
            rd_ptr_reg <= load ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(load);
            if (load) begin
                out_valid <= 1'b1;
                out_data <= mem[rd_ptr_reg];
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    no_overflow_a: assert property (cnt_reg <= FULL_CNT)
        else $error("FIFO count exceeds depth");
    held_output_a: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_data))
        else $error("FIFO output changed while stalled");

endmodule : pinit_fifo

`default_nettype wire

//--- bench/pinit_rx_model.sv
// Receiver model: sync pulses, a stalling ready and capture of words.
`timescale 1ns/1ps
`default_nettype none

module pinit_rx_model
    import pinit_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tx_valid,
    input wire pinit_word_type tx_word,
    output logic tx_ready,
    output logic sync_pulse
);
    logic [5:0] cnt;
    pinit_word_type rx_q[$];

    // Ready drops one cycle in four so the output stage must hold a word.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 6'h00;
            tx_ready <= 1'b0;
            sync_pulse <= 1'b0;
            rx_q.delete();
        end else begin
            cnt <= (cnt == 6'h2f) ? 6'h00 : cnt + 6'h01;
            tx_ready <= (cnt[1:0] != 2'h0);
            sync_pulse <= (cnt < 6'h03);
            if (tx_valid && tx_ready) begin
                rx_q.push_back(tx_word);
            end
        end
    end
endmodule : pinit_rx_model

`default_nettype wire

//--- bench/psi5_init_sequencer_test.sv
// Self-checking bench for the initialization sequencer.
`timescale 1ns/1ps
`default_nettype none

module psi5_init_sequencer_test
    import pinit_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic prog = 1'b0;
    logic st_done = 1'b0;
    logic st_fail = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic sync_pulse, tx_ready, tx_valid, normal;
    logic [1:0] phase;
    pinit_word_type tx_word;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;

    pinit_sequencer #(.POR_SETTLE_US(16'd2), .FILTER_START_US(16'd2),
        .PME_WINDOW_US(16'd3)) u_dut (.SYS_CLK(clk), .RST_B(rst_b),
        .ADDR(addr), .WDATA(wdata), .WR(wr_en), .RD(rd_en), .RDATA(rdata),
        .SYNC_PULSE(sync_pulse), .PROG_ENTRY(prog), .SELFTEST_DONE(st_done),
        .SELFTEST_FAIL(st_fail), .TX_READY(tx_ready), .TX_VALID(tx_valid),
        .TX_WORD(tx_word), .INIT_PHASE(phase), .NORMAL_MODE(normal));
    pinit_rx_model u_rx (.clk(clk), .rst_b(rst_b), .tx_valid(tx_valid),
        .tx_word(tx_word), .tx_ready(tx_ready), .sync_pulse(sync_pulse));

    always #12.5 clk = ~clk;

    task automatic finish_test();
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test

    // Three full sequences fit well inside this ceiling.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 check(rdata, e);
    endtask : reg_rd

    task automatic start(input logic p, input logic f);
        rst_b <= 1'b0;
        prog <= p;
        st_fail <= f;
        st_done <= 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1 check(phase, 32'h1);
    endtask : start

    // Words per nibble: k=4 repetitions of ID then data, each in ns slots.
    task automatic run(input logic [7:0] cfg, input logic [31:0] user,
            input int ns, input logic [9:0] fin);
        int k;
        logic [3:0] v;
        logic [9:0] c;
        start(1'b0, fin != CODE_READY);
        reg_wr(REG_CFG_OFF, {24'h0, cfg});
        reg_wr(REG_USER_OFF, user);
        reg_rd(REG_CFG_OFF, {24'h0, cfg});
        reg_rd(REG_USER_OFF, user);
        reg_rd(8'h0c, 32'h0);
        reg_rd(REG_STAT_OFF, 32'h0001_0001);
        for (k = 0; k < 2000 && phase === 2'h1; k++) @(posedge clk);
        check(u_rx.rx_q.size(), 32'h0);
        for (k = 0; k < 40000 && phase !== 2'h3; k++) @(posedge clk);
        repeat (200) @(posedge clk);
        for (int n = 1; n <= (cfg[2] ? 48 : 32); n++) begin
            v = (n == 1) ? user[3:0] : (n == 2) ? {3'h1, cfg[2]} :
                (n > 3 && n < 10) ? user[4*(n-2) +: 4] : 4'h0;
            for (int i = 0; i < 8 * ns; i++) begin
                c = (i % (2 * ns) >= ns) ? 10'h210 + v :
                    10'h200 + 10'((n - 1) % 16);
                check(u_rx.rx_q.pop_front(), {2'(i % ns), c});
            end
        end
        check(u_rx.rx_q[0].code, CODE_BUSY);
        st_done <= 1'b1;
        for (k = 0; k < 2000 && normal !== 1'b1; k++) @(posedge clk);
        repeat (200) @(posedge clk);
        while (u_rx.rx_q.size() > 0 && u_rx.rx_q[0].code === CODE_BUSY)
            void'(u_rx.rx_q.pop_front());
        for (int i = 0; i < ns; i++)
            check(u_rx.rx_q.pop_front(), {2'(i), fin});
        check({phase, normal}, 32'h1);
    endtask : run

    initial begin
        run(8'h31, 32'h8765_4321, 2, CODE_READY);
        run(8'h3d, 32'h0fa5_5a3c, 2, CODE_ST_ERR);
        run(8'h32, 32'h1234_5678, 1, CODE_DEFECT);
        start(1'b1, 1'b0);
        repeat (2000) @(posedge clk);
        check({phase, u_rx.rx_q.size() > 0}, 32'h2);
        reg_rd(REG_STAT_OFF, 32'h0001_0009);
        // The reset configuration selects asynchronous mode; only the first
        // two self-paced periods fit the run time.
        start(1'b0, 1'b0);
        for (int k = 0; k < 22000 && u_rx.rx_q.size() < 2; k++)
            @(posedge clk);
        check(u_rx.rx_q.pop_front(), {2'd0, 10'h200});
        check(u_rx.rx_q.pop_front(), {2'd0, 10'h210});
        finish_test();
    end
endmodule : psi5_init_sequencer_test

`default_nettype wire
